// *** bench/bus_model.sv ***
// Bus-side model: tallies and vets the bus cycles that the decoder runs
`timescale 1ns/1ps
`default_nettype none
module bus_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        clear_in,
	input  wire logic [15:0] addr_in,
	input  wire logic        read_in,
	input  wire logic        status_in,
	input  wire logic [2:0]  kind_in,
	input  wire logic [15:0] oper_addr_in,
	input  wire logic [15:0] stack_addr_in,
	output logic [3:0]       reads_out,
	output logic [3:0]       writes_out,
	output logic [3:0]       faults_out
);
	logic bad;

	// Address and direction must fit the cycle kind; x counts as bad too
	always_comb begin
		bad = status_in !== 1'b0;
		case (kind_in)
			opdec_pkg::BUS_IDLE:
				bad = bad || addr_in !== 16'hFFFF || read_in !== 1'b1;
			opdec_pkg::BUS_ADDR_READ:
				bad = bad || addr_in !== oper_addr_in || read_in !== 1'b1;
			opdec_pkg::BUS_ADDR_WRITE:
				bad = bad || addr_in !== oper_addr_in || read_in !== 1'b0;
			opdec_pkg::BUS_STACK_WRITE:
				bad = bad || addr_in !== stack_addr_in || read_in !== 1'b0;
			default:
				bad = bad;
		endcase
	end

	// Counters wrap past 15, never in practice: sequences are under ten cycles
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			reads_out <= 4'h0;
			writes_out <= 4'h0;
			faults_out <= 4'h0;
		end else begin
			if (kind_in == opdec_pkg::BUS_ADDR_READ)
				reads_out <= reads_out + 4'h1;
			if (read_in === 1'b0)
				writes_out <= writes_out + 4'h1;
			if (bad)
				faults_out <= faults_out + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Testbench: opcode decoder with bus model and scenario tasks
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        byte_valid = 1'b0;
	logic [7:0]  byte_data = 8'h00;
	logic        post_valid = 1'b0;
	logic [7:0]  post_data = 8'h00;
	logic        taken = 1'b0;
	logic [4:0]  extra = 5'h00;
	logic        clr = 1'b0;
	logic [15:0] oper_addr = 16'h1234;
	logic [15:0] stack_addr = 16'h0FF0;
	logic        dec_valid, illegal, post_ok, busy, bus_read, bus_status;
	logic [4:0]  op_class, cycles;
	logic [2:0]  mode, bus_kind;
	logic [1:0]  nbytes;
	logic [7:0]  stack_mask;
	logic [15:0] bus_addr;
	logic [3:0]  reads, writes, faults;
	int          err_total = 0;
	int          checks_done = 0;

	// 25 MHz core clock
	always #20 core_clk = ~core_clk;

	cpu8_opcode_decoder dut (.core_clk_in(core_clk), .rst_in(rst),
		.byte_valid_in(byte_valid), .byte_in(byte_data),
		.postbyte_valid_in(post_valid), .postbyte_in(post_data),
		.branch_taken_in(taken), .extra_cycles_in(extra),
		.operand_addr_in(oper_addr), .stack_addr_in(stack_addr),
		.decode_valid_out(dec_valid), .op_class_out(op_class),
		.addr_mode_out(mode), .cycles_out(cycles), .bytes_out(nbytes),
		.illegal_out(illegal), .postbyte_ok_out(post_ok),
		.stack_sel_mask_out(stack_mask), .busy_out(busy),
		.bus_addr_out(bus_addr), .bus_read_out(bus_read),
		.bus_status_line_out(bus_status), .bus_kind_out(bus_kind));

	bus_model mem (.clk_in(core_clk), .rst_in(rst), .clear_in(clr),
		.addr_in(bus_addr), .read_in(bus_read), .status_in(bus_status),
		.kind_in(bus_kind), .oper_addr_in(oper_addr),
		.stack_addr_in(stack_addr), .reads_out(reads),
		.writes_out(writes), .faults_out(faults));

	task automatic conclude();
		$display("Mismatches %0d in %0d checks", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic compare(input logic [15:0] got, exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask

	// Inputs move 1 ns after the rising edge
	task automatic step();
		@(posedge core_clk);
		#1;
	endtask

	// Offer an optional page prefix and an opcode, then judge the answer
	task automatic decode(input logic [7:0] pre, op, input logic [4:0] cyc,
			input logic [1:0] nb, input logic ill);
		int i;
		byte_valid = 1'b1;
		if (pre[7:1] == 7'h08) begin
			byte_data = pre;
			step();
		end
		byte_data = op;
		step();
		byte_valid = 1'b0;
		for (i = 0; i < 4 && dec_valid !== 1'b1; i++)
			step();
		if (dec_valid !== 1'b1) begin
			err_total++;
			conclude();
		end
		compare(cycles, cyc, "cycle count");
		if (nb !== 2'h0)
			compare(nbytes, nb, "byte count");
		compare(illegal, ill, "unused flag");
		step();
		compare(dec_valid, 1'b0, "valid pulse length");
	endtask

	// A byte held on the input while busy must be refused
	task automatic wait_idle();
		int i;
		for (i = 0; i < 40 && busy !== 1'b0; i++) begin
			if (dec_valid !== 1'b0)
				compare(dec_valid, 1'b0, "refused byte");
			step();
		end
		if (busy !== 1'b0) begin
			err_total++;
			conclude();
		end
	endtask

	task automatic post(input logic [7:0] pb, input logic ok);
		post_valid = 1'b1;
		post_data = pb;
		step();
		post_valid = 1'b0;
		step();
		compare(post_ok, ok, "postbyte pair");
	endtask

	task automatic t_seq(input logic [7:0] op, input logic [4:0] cyc,
			input logic [3:0] nr, nw);
		clr = 1'b1;
		step();
		clr = 1'b0;
		decode(8'h00, op, cyc, 2'h3, 1'b0);
		byte_valid = 1'b1;
		byte_data = 8'h3D;
		wait_idle();
		byte_valid = 1'b0;
		step();
		step();
		compare(reads, nr, "operand reads");
		compare(writes, nw, "write cycles");
		compare(faults, 4'h0, "bus cycle faults");
	endtask

	initial begin
		repeat (3) step();
		rst = 1'b0;
		compare(busy, 1'b0, "busy after reset");
		compare(bus_addr, 16'hFFFF, "idle address");
		compare(bus_read, 1'b1, "idle read");
		compare(stack_mask[3:0], 4'hF, "A B flags page");
		compare(stack_mask[6], 1'b0, "own pointer");
		decode(8'h00, 8'h3D, 5'h0B, 2'h1, 1'b0);
		compare(op_class, 5'(opdec_pkg::OPC_UNS_MUL), "class");
		decode(8'h00, 8'h1D, 5'h02, 2'h1, 1'b0);
		decode(8'h00, 8'h3A, 5'h03, 2'h1, 1'b0);
		decode(8'h00, 8'h3C, 5'h14, 2'h2, 1'b0);
		decode(8'h00, 8'h13, 5'h02, 2'h1, 1'b0);
		decode(8'h00, 8'h3F, 5'h13, 2'h1, 1'b0);
		decode(8'h00, 8'h37, 5'h05, 2'h2, 1'b0);
		decode(8'h00, 8'h1F, 5'h06, 2'h2, 1'b0);
		decode(8'h00, 8'h19, 5'h02, 2'h1, 1'b0);
		decode(8'h00, 8'h1A, 5'h03, 2'h2, 1'b0);
		decode(8'h00, 8'h1C, 5'h03, 2'h2, 1'b0);
		decode(8'h00, 8'h39, 5'h05, 2'h1, 1'b0);
		decode(8'h00, 8'h3B, 5'h06, 2'h1, 1'b0);
		decode(8'h00, 8'h16, 5'h05, 2'h3, 1'b0);
		decode(8'h00, 8'h8D, 5'h07, 2'h2, 1'b0);
		decode(8'h00, 8'h0F, 5'h06, 2'h2, 1'b0);
		compare(mode, 3'(opdec_pkg::MODE_DIRECT), "direct mode");
		decode(8'h00, 8'h80, 5'h02, 2'h2, 1'b0);
		compare(mode, 3'(opdec_pkg::MODE_IMMED), "immed mode");
		decode(8'h00, 8'h01, 5'h02, 2'h1, 1'b1);
		taken = 1'b1;
		decode(8'h00, 8'h2F, 5'h03, 2'h2, 1'b0);
		decode(8'h10, 8'h22, 5'h06, 2'h0, 1'b0);
		taken = 1'b0;
		decode(8'h10, 8'h2F, 5'h05, 2'h0, 1'b0);
		decode(8'h10, 8'h83, 5'h05, 2'h0, 1'b0);
		compare(op_class, 5'(opdec_pkg::OPC_CMP_D), "page op");
		decode(8'h10, 8'h3F, 5'h14, 2'h0, 1'b0);
		decode(8'h11, 8'h3F, 5'h14, 2'h0, 1'b0);
		extra = 5'h03;
		decode(8'h00, 8'h34, 5'h08, 2'h2, 1'b0);
		decode(8'h00, 8'h6A, 5'h09, 2'h0, 1'b0);
		compare(mode, 3'(opdec_pkg::MODE_INDEXED), "indexed");
		extra = 5'h00;
		decode(8'h00, 8'h1E, 5'h08, 2'h2, 1'b0);
		post(8'h12, 1'b1);
		post(8'h89, 1'b1);
		post(8'h08, 1'b0);
		post(8'h61, 1'b0);
		post(8'hB5, 1'b0);
		t_seq(8'h17, 5'h09, 4'h1, 4'h2);
		t_seq(8'h7A, 5'h07, 4'h1, 4'h1);
		conclude();
	end
endmodule
`default_nettype wire

// *** verilog/cpu8_opcode_decoder.sv ***
// Top: opcode decoder with page prefixes and bus-cycle sequencing
// Overview of operation
// - Table counts are base; extras added on
// - Long call sequences six ordered bus cycles, steps 3 to 8
// - 3D unsigned multiply, 11 cycles, one byte
// - 1D sign-extends B into A, 2 cycles
// - 3A adds B to X, 3 cycles
// - 3C masks flags then waits, 20 cycles
// - 13 halts until interrupt, 2 cycles
// - Traps 3F 19, prefixed 3F 20 cycles
// - 34 to 37 stack push/pull, 5+ cycles
// - Swap 8, copy 6; like sizes only
// - Short branch 3; long 5, taken 6
// - Short call 7, long call 9, long 5
// - 19 decimal adjust, 2 cycles, one byte
// - 1A OR, 1C AND into flags, 3 cycles
// - 39 return 5 cycles, 3B interrupt return
// - Modify rows: direct, indexed, extended counts
// - Row 80 immediate A ops, 2 cycles
// - A, B, flags, page selectable for stacks
// - Postbyte: high nibble source, low destination
// - Idle cycle drives FFFF, read, status low
`timescale 1ns/1ps
`default_nettype none
module cpu8_opcode_decoder (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        byte_valid_in,
	input  wire logic [7:0]  byte_in,
	input  wire logic        postbyte_valid_in,
	input  wire logic [7:0]  postbyte_in,
	input  wire logic        branch_taken_in,
	input  wire logic [4:0]  extra_cycles_in,
	input  wire logic [15:0] operand_addr_in,
	input  wire logic [15:0] stack_addr_in,
	output logic             decode_valid_out,
	output logic [4:0]       op_class_out,
	output logic [2:0]       addr_mode_out,
	output logic [4:0]       cycles_out,
	output logic [1:0]       bytes_out,
	output logic             illegal_out,
	output logic             postbyte_ok_out,
	output logic [7:0]       stack_sel_mask_out,
	output logic             busy_out,
	output logic [15:0]      bus_addr_out,
	output logic             bus_read_out,
	output logic             bus_status_line_out,
	output logic [2:0]       bus_kind_out
);
	// Sequencer phases
	typedef enum logic [1:0] {ST_FETCH, ST_PREFIXED, ST_SEQ} phase_e;

	typedef struct packed {
		phase_e             phase;
		logic [1:0]         page;
		logic               valid;
		opdec_pkg::decode_s res;
		logic               post_ok;
		logic [3:0]         step;
		logic               seq_call;
		logic [15:0]        addr;
		logic               rd;
		logic [2:0]         kind;
	} state_s;

	state_s cur;
	state_s next_cur;

	opdec_if dec ();
	assign dec.opcode = byte_in;
	assign dec.page   = cur.page;

	opdec_lookup u_lookup (
		.dec (dec)
	);

	// Postbyte check: like sizes only, defined codes only
	function automatic logic pair_ok(input logic [7:0] pb);
		logic [3:0] s;
		logic [3:0] d;
		s = pb[opdec_pkg::POST_SRC_LSB +: 4];
		d = pb[opdec_pkg::POST_DST_LSB +: 4];
		return ((s <= opdec_pkg::REG16_LAST) && (d <= opdec_pkg::REG16_LAST))
			|| ((s >= opdec_pkg::REG8_FIRST) && (s <= opdec_pkg::REG8_LAST)
			&& (d >= opdec_pkg::REG8_FIRST) && (d <= opdec_pkg::REG8_LAST));
	endfunction

	// Bus kind of each step of the two sequenced instructions
	function automatic opdec_pkg::bus_kind_e seq_kind(
		input logic call, input logic [3:0] st);
		if (st < 4'h3)
			return opdec_pkg::BUS_FETCH;
		if (call) begin
			case (st)
				4'h5:    return opdec_pkg::BUS_ADDR_READ;
				4'h7,
				4'h8:    return opdec_pkg::BUS_STACK_WRITE;
				default: return opdec_pkg::BUS_IDLE;
			endcase
		end
		case (st)
			4'h4:    return opdec_pkg::BUS_ADDR_READ;
			4'h6:    return opdec_pkg::BUS_ADDR_WRITE;
			default: return opdec_pkg::BUS_IDLE;
		endcase
	endfunction

	// Next-state computation
	always_comb begin
		opdec_pkg::bus_kind_e k;
		next_cur = cur;
		next_cur.valid = 1'b0;
		k = opdec_pkg::BUS_IDLE;
		case (cur.phase)
			ST_FETCH,
			ST_PREFIXED: begin
				if (byte_valid_in) begin
					if (cur.phase == ST_FETCH && (byte_in == opdec_pkg::PAGE2_PREFIX
						|| byte_in == opdec_pkg::PAGE3_PREFIX)) begin
						next_cur.phase = ST_PREFIXED;
						next_cur.page = (byte_in == opdec_pkg::PAGE2_PREFIX)
							? 2'h1 : 2'h2;
					end else begin
						next_cur.valid = 1'b1;
						next_cur.res = dec.result;
						next_cur.page = 2'h0;
						next_cur.phase = ST_FETCH;
						// Add extras on top of base count for every entry flagged variable
						if (dec.result.variable)
							next_cur.res.cycles = dec.result.cycles
								+ extra_cycles_in;
						if (dec.result.op == opdec_pkg::OPC_BRANCH
							&& dec.result.page && branch_taken_in)
							next_cur.res.cycles = opdec_pkg::CYC_LONG_BR
								+ 5'h01;
						if ((cur.page == 2'h0 && byte_in == opdec_pkg::OP_LONG_CALL)
							|| (cur.page == 2'h0 && byte_in == 8'h7A)) begin
							next_cur.phase = ST_SEQ;
							next_cur.seq_call = (byte_in == opdec_pkg::OP_LONG_CALL);
							next_cur.step = 4'h3;
						end
					end
				end
				if (postbyte_valid_in)
					next_cur.post_ok = pair_ok(postbyte_in);
			end
			ST_SEQ: begin
				k = seq_kind(cur.seq_call, cur.step);
				next_cur.step = cur.step + 4'h1;
				if ((cur.seq_call && cur.step == 4'h8)
					|| (!cur.seq_call && cur.step == 4'h6)) begin
					next_cur.phase = ST_FETCH;
					next_cur.step = 4'h0;
				end
			end
			default: next_cur.phase = ST_FETCH;
		endcase
		// Bus appearance for the next cycle
		next_cur.kind = k;
		next_cur.rd = 1'b1;
		next_cur.addr = opdec_pkg::IDLE_ADDR;
		if (k == opdec_pkg::BUS_ADDR_READ || k == opdec_pkg::BUS_ADDR_WRITE)
			next_cur.addr = operand_addr_in;
		if (k == opdec_pkg::BUS_STACK_WRITE)
			next_cur.addr = stack_addr_in;
		if (k == opdec_pkg::BUS_ADDR_WRITE || k == opdec_pkg::BUS_STACK_WRITE)
			next_cur.rd = 1'b0;
	end

	// State register
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			cur <= '0;
			cur.res.op <= opdec_pkg::OPC_NOP;
			cur.rd <= 1'b1;
			cur.addr <= opdec_pkg::IDLE_ADDR;
			cur.kind <= 3'(opdec_pkg::BUS_IDLE);
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs straight from the state register, bar the constant stack mask and status line
	assign decode_valid_out = cur.valid;
	assign op_class_out     = cur.res.op;
	assign addr_mode_out    = cur.res.mode;
	assign cycles_out       = cur.res.cycles;
	assign bytes_out        = cur.res.bytes;
	assign illegal_out      = cur.valid && !cur.res.legal;
	assign postbyte_ok_out  = cur.post_ok;
	// All of A, B, flags, page bits always allowed; stack own pointer masked
	assign stack_sel_mask_out = 8'hBF;
	assign busy_out         = (cur.phase != ST_FETCH);
	assign bus_addr_out     = cur.addr;
	assign bus_read_out     = cur.rd;
	assign bus_status_line_out = 1'b0;
	assign bus_kind_out     = cur.kind;

	// Assertions
	a_idle_bus_shape: assert property (@(posedge core_clk_in) disable iff (rst_in)
		bus_kind_out == 3'(opdec_pkg::BUS_IDLE) |-> bus_addr_out == 16'hFFFF
		&& bus_read_out) else $error("idle cycle bus wrong");
	a_mul_decode: assert property (@(posedge core_clk_in) disable iff (rst_in)
		byte_valid_in && cur.phase == ST_FETCH && byte_in == 8'h3D |=>
		cycles_out == 5'h0B && bytes_out == 2'h1)
		else $error("mul decode");
	a_sext_decode: assert property (@(posedge core_clk_in) disable iff (rst_in)
		byte_valid_in && cur.phase == ST_FETCH && byte_in == 8'h1D |=>
		cycles_out == 5'h02) else $error("sign extend decode");
	a_mask_and_wait_op_decode: assert property (@(posedge core_clk_in) disable iff (rst_in)
		byte_valid_in && cur.phase == ST_FETCH && byte_in == 8'h3C |=>
		cycles_out == 5'h14 && bytes_out == 2'h2)
		else $error("mask wait");
	a_trap_decode: assert property (@(posedge core_clk_in) disable iff (rst_in)
		byte_valid_in && cur.phase == ST_FETCH && byte_in == 8'h3F |=>
		cycles_out == 5'h13) else $error("soft trap count");
	a_prefix_trap: assert property (@(posedge core_clk_in) disable iff (rst_in)
		byte_valid_in && cur.phase == ST_FETCH && byte_in == 8'h10 ##1
		byte_valid_in && byte_in == 8'h3F |=> cycles_out == 5'h14)
		else $error("prefixed trap count");
	// A pending prefix also raises busy, so only a running sequence counts
	a_call_length: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(busy_out) && cur.phase == ST_SEQ && cur.seq_call |->
		busy_out [*6] ##1 !busy_out)
		else $error("long call length");
	a_dec_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(busy_out) && cur.phase == ST_SEQ && !cur.seq_call |->
		##4 !bus_read_out)
		else $error("extended decrement write");
	a_status_low: assert property (@(posedge core_clk_in) disable iff (rst_in)
		!bus_status_line_out) else $error("bus status high");

	c_long_call: cover property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(busy_out) && cur.phase == ST_SEQ && cur.seq_call);
	c_ext_dec: cover property (@(posedge core_clk_in) disable iff (rst_in)
		$rose(busy_out) && cur.phase == ST_SEQ && !cur.seq_call);
	c_illegal: cover property (@(posedge core_clk_in) disable iff (rst_in)
		illegal_out);
	c_prefixed: cover property (@(posedge core_clk_in) disable iff (rst_in)
		decode_valid_out && cur.res.page);
endmodule
`default_nettype wire

// *** verilog/opdec_if.sv ***
// Interface: decoded result carried from the lookup to the sequencer
`timescale 1ns/1ps
`default_nettype none
interface opdec_if;
	logic [7:0]          opcode;
	logic [1:0]          page;
	opdec_pkg::decode_s  result;

	modport lookup (input opcode, input page, output result);
	modport user   (output opcode, output page, input result);
endinterface
`default_nettype wire

// *** verilog/opdec_lookup.sv ***
// Module: combinational opcode lookup over the three opcode pages
`timescale 1ns/1ps
`default_nettype none
module opdec_lookup (
	opdec_if.lookup dec
);
	// Builds one result record
	function automatic opdec_pkg::decode_s mk(
		input opdec_pkg::op_class_e  op,
		input opdec_pkg::addr_mode_e mode,
		input logic [4:0]            cyc,
		input logic [1:0]            nb,
		input logic                  var_cyc
	);
		opdec_pkg::decode_s r;
		r.op = op;
		r.mode = mode;
		r.cycles = cyc;
		r.bytes = nb;
		r.variable = var_cyc;
		r.page = 1'b0;
		r.legal = (op != opdec_pkg::OPC_ILLEGAL);
		return r;
	endfunction

	// Page 1 table; unused slots decode as a harmless illegal no-op
	always_comb begin
		logic [7:0] o;
		o = dec.opcode;
		dec.result = mk(opdec_pkg::OPC_ILLEGAL, opdec_pkg::MODE_INHERENT,
			opdec_pkg::CYC_NOP, 2'h1, 1'b0);
		if (dec.page == 2'h0) begin
			case (o)
				8'h12: dec.result = mk(opdec_pkg::OPC_NOP, opdec_pkg::MODE_INHERENT,
					opdec_pkg::CYC_NOP, 2'h1, 1'b0);
				opdec_pkg::OP_HALT_WAIT: dec.result = mk(opdec_pkg::OPC_HALT_WAIT,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_HALT_WAIT, 2'h1,
					1'b0);
				opdec_pkg::OP_LONG_ALWAYS: dec.result = mk(opdec_pkg::OPC_BRANCH,
					opdec_pkg::MODE_RELATIVE, opdec_pkg::CYC_LONG_ALWAYS, 2'h3,
					1'b0);
				opdec_pkg::OP_LONG_CALL: dec.result = mk(opdec_pkg::OPC_CALL,
					opdec_pkg::MODE_RELATIVE, opdec_pkg::CYC_LONG_CALL, 2'h3,
					1'b0);
				opdec_pkg::OP_BCD_ADJUST: dec.result = mk(opdec_pkg::OPC_BCD_ADJUST,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_INHERENT, 2'h1,
					1'b0);
				opdec_pkg::OP_FLAGS_OR: dec.result = mk(opdec_pkg::OPC_FLAGS_OR,
					opdec_pkg::MODE_IMMED, opdec_pkg::CYC_FLAGS_IMM, 2'h2,
					1'b0);
				opdec_pkg::OP_FLAGS_AND: dec.result = mk(opdec_pkg::OPC_FLAGS_AND,
					opdec_pkg::MODE_IMMED, opdec_pkg::CYC_FLAGS_IMM, 2'h2,
					1'b0);
				opdec_pkg::OP_SIGN_EXT: dec.result = mk(opdec_pkg::OPC_SIGN_EXT,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_INHERENT, 2'h1,
					1'b0);
				opdec_pkg::OP_SWAP_REGS: dec.result = mk(opdec_pkg::OPC_SWAP,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_SWAP_REGS, 2'h2,
					1'b0);
				opdec_pkg::OP_COPY_REG: dec.result = mk(opdec_pkg::OPC_COPY,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_COPY_REG, 2'h2,
					1'b0);
				8'h34: dec.result = mk(opdec_pkg::OPC_PUSH_SYS,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_STACK_OP, 2'h2,
					1'b1);
				8'h35: dec.result = mk(opdec_pkg::OPC_PULL_SYS,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_STACK_OP, 2'h2,
					1'b1);
				8'h36: dec.result = mk(opdec_pkg::OPC_PUSH_USR,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_STACK_OP, 2'h2,
					1'b1);
				8'h37: dec.result = mk(opdec_pkg::OPC_PULL_USR,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_STACK_OP, 2'h2,
					1'b1);
				opdec_pkg::OP_SUB_RETURN: dec.result = mk(opdec_pkg::OPC_SUB_RETURN,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_SUB_RETURN, 2'h1,
					1'b0);
				opdec_pkg::OP_ADD_B_INDEX: dec.result = mk(
					opdec_pkg::OPC_ADD_B_INDEX, opdec_pkg::MODE_INHERENT,
					opdec_pkg::CYC_ADD_B_INDEX, 2'h1, 1'b0);
				opdec_pkg::OP_INT_RETURN: dec.result = mk(opdec_pkg::OPC_INT_RETURN,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_INT_RETURN, 2'h1,
					1'b1);
				opdec_pkg::OP_MASK_WAIT: dec.result = mk(opdec_pkg::OPC_MASK_WAIT,
					opdec_pkg::MODE_IMMED, opdec_pkg::CYC_MASK_WAIT, 2'h2,
					1'b0);
				opdec_pkg::OP_UNS_MUL: dec.result = mk(opdec_pkg::OPC_UNS_MUL,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_UNS_MUL, 2'h1,
					1'b0);
				opdec_pkg::OP_SOFT_TRAP: dec.result = mk(opdec_pkg::OPC_SOFT_TRAP,
					opdec_pkg::MODE_INHERENT, opdec_pkg::CYC_SOFT_TRAP1, 2'h1,
					1'b0);
				opdec_pkg::OP_SHORT_CALL: dec.result = mk(opdec_pkg::OPC_CALL,
					opdec_pkg::MODE_RELATIVE, opdec_pkg::CYC_SHORT_CALL, 2'h2,
					1'b0);
				default: begin
					// Row decode for branches, memory modify and A-operand rows 8x to Bx
					if (o[7:4] == 4'h2)
						dec.result = mk(opdec_pkg::OPC_BRANCH,
							opdec_pkg::MODE_RELATIVE, opdec_pkg::CYC_SHORT_BR, 2'h2,
							1'b0);
					else if (rmw_slot(o[3:0]) && o[7:4] == 4'h0)
						dec.result = mk(opdec_pkg::OPC_RMW, opdec_pkg::MODE_DIRECT,
							opdec_pkg::CYC_RMW_DIRECT, 2'h2, 1'b0);
					else if (rmw_slot(o[3:0]) && o[7:4] == 4'h6)
						dec.result = mk(opdec_pkg::OPC_RMW, opdec_pkg::MODE_INDEXED,
							opdec_pkg::CYC_RMW_INDEXED, 2'h2, 1'b1);
					else if (rmw_slot(o[3:0]) && o[7:4] == 4'h7)
						dec.result = mk(opdec_pkg::OPC_RMW, opdec_pkg::MODE_EXTENDED,
							opdec_pkg::CYC_RMW_EXT, 2'h3, 1'b0);
					else if (o[7:4] == 4'h8 && o != 8'h83 && o != 8'h87
						&& o[3:0] < 4'hC)
						dec.result = mk(opdec_pkg::OPC_ALU_A, opdec_pkg::MODE_IMMED,
							opdec_pkg::CYC_ALU_IMM8, 2'h2, 1'b0);
					else if (o[7:4] >= 4'h9 && o[7:4] <= 4'hB && o[3:0] < 4'hC
						&& o[3:0] != 4'h3 && !(o[7:4] == 4'h9 && o[3:0] == 4'h7))
						dec.result = mk(opdec_pkg::OPC_ALU_A, row_mode(o[7:4]),
							opdec_pkg::CYC_NOP, 2'h2, 1'b1);
					else if (o >= 8'h30)
						dec.result = mk(opdec_pkg::OPC_OTHER, opdec_pkg::MODE_INHERENT,
							opdec_pkg::CYC_NOP, 2'h1, 1'b1);
				end
			endcase
		end else begin
			// Extended pages
			if (dec.page == 2'h1 && o[7:4] == 4'h2 && o != 8'h20)
				dec.result = mk(opdec_pkg::OPC_BRANCH, opdec_pkg::MODE_RELATIVE,
					opdec_pkg::CYC_LONG_BR, 2'h3, 1'b1);
			else if (o == opdec_pkg::OP_SOFT_TRAP)
				dec.result = mk(opdec_pkg::OPC_SOFT_TRAP, opdec_pkg::MODE_INHERENT,
					opdec_pkg::CYC_SOFT_TRAP23, 2'h2, 1'b0);
			else if (o == opdec_pkg::OP_CMP_IMM16)
				dec.result = mk(opdec_pkg::OPC_CMP_D, opdec_pkg::MODE_IMMED,
					opdec_pkg::CYC_CMP_IMM16, 2'h3, 1'b0);
			else if (o >= 8'h80)
				dec.result = mk(opdec_pkg::OPC_OTHER, row_mode(o[7:4]),
					opdec_pkg::CYC_NOP, 2'h3, 1'b1);
			dec.result.page = 1'b1;
		end
	end

	// Read-modify-write slots used in a memory row
	function automatic logic rmw_slot(input logic [3:0] lo);
		return !(lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'hB);
	endfunction

	// Mode implied by the row of an operand opcode
	function automatic opdec_pkg::addr_mode_e row_mode(input logic [3:0] hi);
		case (hi[1:0])
			2'h0:    return opdec_pkg::MODE_IMMED;
			2'h1:    return opdec_pkg::MODE_DIRECT;
			2'h2:    return opdec_pkg::MODE_INDEXED;
			default: return opdec_pkg::MODE_EXTENDED;
		endcase
	endfunction
endmodule
`default_nettype wire

// *** verilog/opdec_pkg.sv ***
// Package: opcode decoder constants, enums and field layouts
package opdec_pkg;

	// Prefix bytes that open the extended pages
	localparam logic [7:0] PAGE2_PREFIX = 8'h10;
	localparam logic [7:0] PAGE3_PREFIX = 8'h11;

	// Individually decoded opcodes
	localparam logic [7:0] OP_HALT_WAIT   = 8'h13;
	localparam logic [7:0] OP_LONG_ALWAYS = 8'h16;
	localparam logic [7:0] OP_LONG_CALL   = 8'h17;
	localparam logic [7:0] OP_BCD_ADJUST  = 8'h19;
	localparam logic [7:0] OP_FLAGS_OR    = 8'h1A;
	localparam logic [7:0] OP_FLAGS_AND   = 8'h1C;
	localparam logic [7:0] OP_SIGN_EXT    = 8'h1D;
	localparam logic [7:0] OP_SWAP_REGS   = 8'h1E;
	localparam logic [7:0] OP_COPY_REG    = 8'h1F;
	localparam logic [7:0] OP_SUB_RETURN  = 8'h39;
	localparam logic [7:0] OP_ADD_B_INDEX = 8'h3A;
	localparam logic [7:0] OP_INT_RETURN  = 8'h3B;
	localparam logic [7:0] OP_MASK_WAIT   = 8'h3C;
	localparam logic [7:0] OP_UNS_MUL     = 8'h3D;
	localparam logic [7:0] OP_SOFT_TRAP   = 8'h3F;
	localparam logic [7:0] OP_SHORT_CALL  = 8'h8D;
	localparam logic [7:0] OP_CMP_IMM16   = 8'h83;

	// Base cycle counts
	localparam logic [4:0] CYC_HALT_WAIT   = 5'h02;
	localparam logic [4:0] CYC_LONG_ALWAYS = 5'h05;
	localparam logic [4:0] CYC_LONG_CALL   = 5'h09;
	localparam logic [4:0] CYC_FLAGS_IMM   = 5'h03;
	localparam logic [4:0] CYC_INHERENT    = 5'h02;
	localparam logic [4:0] CYC_SWAP_REGS   = 5'h08;
	localparam logic [4:0] CYC_COPY_REG    = 5'h06;
	localparam logic [4:0] CYC_STACK_OP    = 5'h05;
	localparam logic [4:0] CYC_SUB_RETURN  = 5'h05;
	localparam logic [4:0] CYC_ADD_B_INDEX = 5'h03;
	localparam logic [4:0] CYC_INT_RETURN  = 5'h06;
	localparam logic [4:0] CYC_MASK_WAIT   = 5'h14;
	localparam logic [4:0] CYC_UNS_MUL     = 5'h0B;
	localparam logic [4:0] CYC_SOFT_TRAP1  = 5'h13;
	localparam logic [4:0] CYC_SOFT_TRAP23 = 5'h14;
	localparam logic [4:0] CYC_SHORT_CALL  = 5'h07;
	localparam logic [4:0] CYC_SHORT_BR    = 5'h03;
	localparam logic [4:0] CYC_LONG_BR     = 5'h05;
	localparam logic [4:0] CYC_RMW_DIRECT  = 5'h06;
	localparam logic [4:0] CYC_RMW_INDEXED = 5'h06;
	localparam logic [4:0] CYC_RMW_EXT     = 5'h07;
	localparam logic [4:0] CYC_ALU_IMM8    = 5'h02;
	localparam logic [4:0] CYC_CMP_IMM16   = 5'h05;
	localparam logic [4:0] CYC_NOP         = 5'h02;

	// Register codes in the exchange / copy postbyte
	localparam int        POST_SRC_LSB = 4;
	localparam int        POST_DST_LSB = 0;
	localparam logic [3:0] REG16_LAST  = 4'h5;
	localparam logic [3:0] REG8_FIRST  = 4'h8;
	localparam logic [3:0] REG8_LAST   = 4'hB;

	// Idle bus cycle appearance
	localparam logic [15:0] IDLE_ADDR = 16'hFFFF;

	// Operation classes
	typedef enum logic [4:0] {
		OPC_ILLEGAL, OPC_NOP, OPC_HALT_WAIT, OPC_BCD_ADJUST,
		OPC_FLAGS_OR, OPC_FLAGS_AND, OPC_SIGN_EXT, OPC_SWAP,
		OPC_COPY, OPC_PUSH_SYS, OPC_PULL_SYS, OPC_PUSH_USR,
		OPC_PULL_USR, OPC_SUB_RETURN, OPC_ADD_B_INDEX,
		OPC_INT_RETURN, OPC_MASK_WAIT, OPC_UNS_MUL, OPC_SOFT_TRAP,
		OPC_BRANCH, OPC_CALL, OPC_RMW, OPC_ALU_A, OPC_CMP_D,
		OPC_OTHER
	} op_class_e;

	// Addressing modes
	typedef enum logic [2:0] {
		MODE_INHERENT, MODE_IMMED, MODE_DIRECT, MODE_INDEXED,
		MODE_EXTENDED, MODE_RELATIVE
	} addr_mode_e;

	// Bus cycle kinds of a sequenced instruction
	typedef enum logic [2:0] {
		BUS_FETCH, BUS_IDLE, BUS_ADDR_READ, BUS_ADDR_WRITE,
		BUS_STACK_WRITE
	} bus_kind_e;

	// Decoded result
	typedef struct packed {
		op_class_e  op;
		addr_mode_e mode;
		logic [4:0] cycles;
		logic [1:0] bytes;
		logic       variable;
		logic       page;
		logic       legal;
	} decode_s;

endpackage
